// file: src/smc_mode_ctrl.sv
/*
  smc_mode_ctrl: system and mode controller of an audio codec.
  Holds standby/active control, staged input and output path selections,
  a commit that applies both, two busy flags and an event interrupt.
  Assumes an AXI4-Lite master on clk_sys and an asynchronous low reset.
*/
// Design decision made here: register access over AXI4-Lite.
`default_nettype none

module smc_mode_ctrl (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic [smc_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [smc_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [smc_pkg::DATA_W/8-1:0]  s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [smc_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [smc_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               sysActive,
  output logic                               micPathEn,
  output logic                               mixerPathEn,
  output logic                               adcPathEn,
  output logic                               hpLeftEn,
  output logic                               hpRightEn,
  output logic                               dacLeftEn,
  output logic                               dacRightEn,
  output logic                               irq
);

  import smc_pkg::*;

  // write channel holding registers
  logic              awHave_q;  // write address captured
  logic [ADDR_W-1:0] awAddr_q;  // captured write address
  logic              wHave_q;   // write data captured
  logic [DATA_W-1:0] wData_q;   // captured write data
  logic              wStrb0_q;  // lane 0 strobe, the only live lane
  logic              bValid_q;  // write response pending
  logic [1:0]        bResp_q;   // write response code

  // read channel
  logic              rValid_q;  // read data pending
  logic [DATA_W-1:0] rData_q;   // read data
  logic [1:0]        rResp_q;   // read response code

  // register state
  logic [7:1]        inSel_q;   // staged input-side selection
  logic [7:1]        outSel_q;  // staged output-side selection
  logic [7:1]        inApp_q;   // applied input-side selection
  logic [7:1]        outApp_q;  // applied output-side selection
  logic              active_q;  // standby (0) or active (1)
  logic [IRQ_W-1:0]  irqStat_q; // sticky events
  logic [IRQ_W-1:0]  irqMask_q; // event enables

  // mode controller
  smc_mode_e         mode_q;    // current state
  smc_mode_e         mode_d;    // next state

  // decode and strobes
  logic [7:0]        wrIdx;     // register index of the write
  logic              wrOk;      // write hits a mapped register
  logic              doWrite;   // both halves present, response free
  logic              wrEn;      // write actually stores
  logic [7:0]        rdIdx;     // register index of the read
  logic              rdOk;      // read hits a mapped register
  logic              commitReq; // commit written this cycle
  logic              applyNow;  // staged selections move to applied
  logic              sysStart;  // standby/active change requested
  logic              sysBusy;   // system controller running
  logic              sysDone;   // system controller finished
  logic              modeBusy;  // mode controller running
  logic              modeDone;  // mode settle finished
  logic [IRQ_W-1:0]  irqEvt;    // events this cycle
  logic [IRQ_W-1:0]  irqClr;    // write-one-to-clear mask

  // true for each index the block answers
  function automatic logic isMapped(input logic [7:0] idx);
    isMapped = (idx == IDX_INPUT) || (idx == IDX_OUTPUT) ||
               (idx == IDX_STATUS) || (idx == IDX_ACTIVE) ||
               (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
  endfunction : isMapped

  // address is word aligned and inside the 256-word window
  function automatic logic addrOk(input logic [ADDR_W-1:0] a);
    addrOk = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) && isMapped(a[9:2]);
  endfunction : addrOk

  // write address and data are taken independently, in either order;
  // neither is taken again until the response has gone
  assign s_axi_awready = !awHave_q && !bValid_q;
  assign s_axi_wready  = !wHave_q && !bValid_q;
  assign doWrite       = awHave_q && wHave_q && !bValid_q;
  assign wrIdx         = awAddr_q[9:2];
  assign wrOk          = addrOk(awAddr_q);
  // bytes above lane 0 carry nothing, so lane 0 alone gates the store
  assign wrEn          = doWrite && wrOk && wStrb0_q;

  // capture write address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      awAddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_q <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wHave_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_q  <= 1'b1;
      wData_q  <= s_axi_wdata;
      wStrb0_q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHave_q <= 1'b0;
    end
  end

  // write response, error for an unmapped or misaligned address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q  <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp  = bResp_q;

  // read side: one read in flight, data sampled as the address is taken
  assign s_axi_arready = !rValid_q;
  assign rdIdx         = s_axi_araddr[9:2];
  assign rdOk          = addrOk(s_axi_araddr);

  // read data multiplexer; commit bit and output bit 0 read as zero, other reserved selection bits read back as written
  function automatic logic [REG_W-1:0] readReg(input logic [7:0] idx);
    readReg = 8'h00;
    unique case (idx)
      IDX_INPUT:    readReg = {inSel_q, 1'b0};
      IDX_OUTPUT:   readReg = {outSel_q, 1'b0};
      IDX_STATUS:   readReg = {6'h00, modeBusy, sysBusy};
      IDX_ACTIVE:   readReg = {7'h00, active_q};
      IDX_IRQ_STAT: readReg = {6'h00, irqStat_q};
      IDX_IRQ_MASK: readReg = {6'h00, irqMask_q};
      default:      readReg = 8'h00;
    endcase
  endfunction : readReg

  // read response, data zero on error
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q  <= rdOk ? {24'h00_0000, readReg(rdIdx)} : 32'h0000_0000;
      rResp_q  <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata  = rData_q;
  assign s_axi_rresp  = rResp_q;

  // staged path selections; writes only stage, nothing reaches the paths
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inSel_q  <= RST_SEL;
      outSel_q <= RST_SEL;
    end else if (wrEn) begin
      if (wrIdx == IDX_INPUT) begin
        inSel_q <= wData_q[7:1];
      end
      if (wrIdx == IDX_OUTPUT) begin
        outSel_q <= wData_q[7:1];
      end
    end
  end

  assign commitReq = wrEn && (wrIdx == IDX_INPUT) && wData_q[BIT_COMMIT];

  // standby/active control; only a real change starts the sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= RST_ACTIVE;
    end else if (wrEn && wrIdx == IDX_ACTIVE) begin
      active_q <= wData_q[BIT_ACTIVE];
    end
  end

  assign sysStart = wrEn && (wrIdx == IDX_ACTIVE) && (wData_q[BIT_ACTIVE] != active_q);

  // system controller: busy for the power-up or power-down settle time
  smc_settle_timer #(
    .CYCLES (SYS_SETTLE_CYC)
  ) u_sys_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (sysStart),
    .busy    (sysBusy),
    .done    (sysDone)
  );

  // mode controller next state
  always_comb begin
    mode_d   = mode_q;
    applyNow = 1'b0;
    unique case (mode_q)
      MC_IDLE: begin
        if (commitReq) begin
          mode_d = MC_WAIT;
        end
      end
      MC_WAIT: begin
        // a path switch during a power transition would pop, so wait
        if (!sysBusy) begin
          applyNow = 1'b1;
          mode_d   = MC_SETTLE;
        end
      end
      MC_SETTLE: begin
        if (modeDone) begin
          mode_d = MC_IDLE;
        end
      end
      default: begin
        mode_d = MC_IDLE;
      end
    endcase
  end

  // mode controller state; a commit while busy is dropped, software polls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MC_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign modeBusy = (mode_q != MC_IDLE);

  // path settle timer, started as the paths switch
  smc_settle_timer #(
    .CYCLES (MODE_SETTLE_CYC)
  ) u_mode_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (applyNow),
    .busy    (),
    .done    (modeDone)
  );

  // applied selections, both sides move in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inApp_q  <= RST_SEL;
      outApp_q <= RST_SEL;
    end else if (applyNow) begin
      inApp_q  <= inSel_q;
      outApp_q <= outSel_q;
    end
  end

  // path enables straight from the applied flops; reserved bits go nowhere
  assign micPathEn   = inApp_q[BIT_MIC];
  assign mixerPathEn = inApp_q[BIT_MIXER];
  assign adcPathEn   = inApp_q[BIT_ADC];
  assign hpLeftEn    = outApp_q[BIT_HP_L];
  assign hpRightEn   = outApp_q[BIT_HP_R];
  assign dacLeftEn   = outApp_q[BIT_DAC_L];
  assign dacRightEn  = outApp_q[BIT_DAC_R];
  assign sysActive   = active_q;

  // controller completion events
  assign irqEvt = {modeDone, sysDone};
  assign irqClr = (wrEn && wrIdx == IDX_IRQ_STAT) ? wData_q[IRQ_W-1:0] : '0;

  // sticky event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q <= RST_IRQ;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
    end
  end

  // event enables
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqMask_q <= RST_IRQ;
    end else if (wrEn && wrIdx == IDX_IRQ_MASK) begin
      irqMask_q <= wData_q[IRQ_W-1:0];
    end
  end

  // level interrupt while any enabled flag stands
  assign irq = |(irqStat_q & irqMask_q);

endmodule : smc_mode_ctrl

`default_nettype wire

// file: src/smc_pkg.sv
/*
  smc_pkg: constants shared by the audio system mode controller.
  Register indices, field positions, reset values, bus codes and settle times.
  Assumes a single 125 MHz system clock.
*/
`default_nettype none

package smc_pkg;

  // bus geometry
  localparam int ADDR_W = 12;  // byte address width, covers index 0xFF
  localparam int DATA_W = 32;  // AXI4-Lite data width
  localparam int REG_W  = 8;   // every register is one byte wide

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_INPUT    = 8'h50;  // input_path_select
  localparam logic [7:0] IDX_OUTPUT   = 8'h51;  // output_path_select
  localparam logic [7:0] IDX_STATUS   = 8'hE0;  // controller_busy_flags
  localparam logic [7:0] IDX_ACTIVE   = 8'hFD;  // standby_or_active
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF0;  // sticky event flags
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;  // event enables

  // field positions
  localparam int BIT_ACTIVE      = 0;  // standby (0) or active (1)
  localparam int BIT_COMMIT      = 0;  // commit in input_path_select
  localparam int BIT_MIC         = 2;  // microphone_path
  localparam int BIT_MIXER       = 4;  // input_mixer_path
  localparam int BIT_ADC         = 6;  // converter path, input side
  localparam int BIT_HP_L        = 4;  // headphone_left_path
  localparam int BIT_HP_R        = 5;  // headphone_right_path
  localparam int BIT_DAC_L       = 6;  // converter left, output side
  localparam int BIT_DAC_R       = 7;  // converter right, output side
  localparam int BIT_SYS_BUSY    = 0;  // sys_ctrl_busy
  localparam int BIT_MODE_BUSY   = 1;  // mode_ctrl_busy
  localparam int IRQ_SYS_DONE    = 0;  // system controller finished
  localparam int IRQ_MODE_DONE   = 1;  // mode controller finished
  localparam int IRQ_W           = 2;  // number of event bits

  // reset values
  localparam logic [7:1] RST_SEL    = 7'h00;  // no path selected
  localparam logic       RST_ACTIVE = 1'b0;   // standby
  localparam logic [1:0] RST_IRQ    = 2'h0;   // no events, all masked

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // timing
  localparam int CLK_MHZ        = 125;     // system clock rate
  localparam int SYS_SETTLE_NS  = 10_000;  // standby/active transition
  localparam int MODE_SETTLE_NS = 2_000;   // path switch settling
  localparam logic [15:0] SYS_SETTLE_CYC  = 16'((SYS_SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MODE_SETTLE_CYC = 16'((MODE_SETTLE_NS * CLK_MHZ + 999) / 1000);

  // mode controller states, one-hot
  typedef enum logic [2:0] {
    MC_IDLE   = 3'b001,  // nothing pending
    MC_WAIT   = 3'b010,  // commit taken, held while the system controller is busy
    MC_SETTLE = 3'b100   // paths switched, waiting for them to settle
  } smc_mode_e;

endpackage : smc_pkg

`default_nettype wire

// file: src/smc_settle_timer.sv
/*
  smc_settle_timer: one-shot down counter with busy level and done pulse.
  Assumes start is a one-cycle pulse in the clk_sys domain.
*/
`default_nettype none

module smc_settle_timer #(
  parameter logic [15:0] CYCLES = 16'h0001  // busy length in cycles
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [15:0] cnt_q;   // cycles left
  logic        busy_q;  // running
  logic        done_q;  // one-cycle pulse as busy falls

  // a start while running restarts the wait, so the last change always
  // gets its full settle time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= CYCLES;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (busy_q && cnt_q == 16'h0001) begin
      // expiry: busy falls and done pulses in the same cycle
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end else begin
      cnt_q  <= busy_q ? cnt_q - 16'h0001 : cnt_q;
      done_q <= 1'b0;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule : smc_settle_timer

`default_nettype wire

// file: test/smc_mode_ctrl_asserts.sv
/*
  smc_mode_ctrl_asserts: port-level checks of the audio system mode controller.
  Assumes a bind onto smc_mode_ctrl, one clk_sys domain and rst_b active low.
*/
`default_nettype none

module smc_mode_ctrl_asserts (
  input wire logic                       clk_sys,
  input wire logic                       rst_b,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [smc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       sysActive,
  input wire logic                       micPathEn,
  input wire logic                       mixerPathEn,
  input wire logic                       adcPathEn,
  input wire logic                       hpLeftEn,
  input wire logic                       hpRightEn,
  input wire logic                       dacLeftEn,
  input wire logic                       dacRightEn
);
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [6:0] pathNow;  // all applied path enables
  logic [6:0] pathQ;    // enables one cycle ago
  logic [8:0] gapQ;     // cycles since the last path change, saturating

  assign pathNow = {dacRightEn, dacLeftEn, hpRightEn, hpLeftEn, adcPathEn, mixerPathEn, micPathEn};

  // spacing counter: starts saturated so the first commit is never flagged
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pathQ <= 7'h00;
      gapQ  <= 9'h1FF;
    end else begin
      pathQ <= pathNow;
      gapQ  <= (pathNow != pathQ) ? 9'h000 : ((gapQ == 9'h1FF) ? gapQ : gapQ + 9'h001);
    end
  end

  property p_active_on_store;
    $changed(sysActive) |-> $rose(s_axi_bvalid);
  endproperty
  a_active_on_store: assert property (p_active_on_store) else $error("standby control moved without a write");

  // settle time keeps two commits well apart
  property p_path_gap;
    (pathNow != pathQ) |-> gapQ >= 9'h0C8;
  endproperty
  a_path_gap: assert property (p_path_gap) else $error("paths changed again before settling");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");

  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");

  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered in two cycles");

  property p_wblock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblock: assert property (p_wblock) else $error("write accepted while response pending");

  // byte registers: upper read bits always clear
  property p_rblock;
    s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rblock: assert property (p_rblock) else $error("read accepted or wide data while pending");
endmodule : smc_mode_ctrl_asserts

`default_nettype wire

// file: test/testbench.sv
/*
  testbench: self-checking bench of smc_mode_ctrl over AXI4-Lite.
  Assumes the controller settle times from smc_pkg and the checker bound below.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;

  logic        clk_sys, rst_b;                      // clock and low reset
  logic [11:0] s_axi_awaddr, s_axi_araddr;          // byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;            // bus data
  logic [3:0]  s_axi_wstrb;                         // byte enables, all set except in the lane 0 strobe test
  logic [1:0]  s_axi_bresp, s_axi_rresp;            // response codes
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sysActive, irq;
  logic        micPathEn, mixerPathEn, adcPathEn, hpLeftEn, hpRightEn, dacLeftEn, dacRightEn;
  logic [6:0]  paths;                               // applied enables, output side high
  int          error_cnt = 0;                       // mismatches
  int          n_tests = 0;                         // comparisons

  assign paths = {dacRightEn, dacLeftEn, hpRightEn, hpLeftEn, adcPathEn, mixerPathEn, micPathEn};

  smc_mode_ctrl dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sysActive, .micPathEn, .mixerPathEn, .adcPathEn, .hpLeftEn, .hpRightEn,
    .dacLeftEn, .dacRightEn, .irq);

  // free-running 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : adr

  // expected enables from staged input and output selections
  function automatic logic [31:0] exp_paths(input logic [7:0] i, input logic [7:0] o);
    return {25'h000_0000, o[7], o[6], o[5], o[4], i[6], i[4], i[2]};
  endfunction : exp_paths

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // write: address and data offered together, response taken late to show it holds
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      #1;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      #1;
    end while (s_axi_arvalid);
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    d = s_axi_rdata;
    chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, er});
    s_axi_rready <= 1'b0;
  endtask : rd

  // poll the busy flags until both controllers report complete
  task automatic wait_idle();
    logic [31:0] d;
    int          k;
    k = 0;
    do begin
      rd(adr(IDX_STATUS), d, RESP_OKAY);
      k++;
    end while (d !== 32'h0000_0000 && k < 1000);
    chk(d, 32'h0000_0000);
  endtask : wait_idle

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // watchdog: whole run needs well under 20k cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end

  initial begin : main
    logic [31:0] d;
    logic [7:0]  inS, outS;
    logic [7:0]  regs [6] = '{IDX_INPUT, IDX_OUTPUT, IDX_STATUS, IDX_ACTIVE, IDX_IRQ_STAT, IDX_IRQ_MASK};
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h00_0000_0000_0000;
    s_axi_wstrb = 4'hF;
    void'($urandom(46));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      rd(adr(regs[i]), d, RESP_OKAY);
      chk(d, 32'h0000_0000);
    end
    chk({29'h0000_0000, sysActive, irq, |paths}, 32'h0000_0000);
    $display("test reset values done");
    // staged selections must not reach the paths without a commit
    inS  = 8'($urandom) & 8'hFE;
    outS = 8'($urandom);
    wr(adr(IDX_INPUT), inS, RESP_OKAY);
    wr(adr(IDX_OUTPUT), outS, RESP_OKAY);
    rd(adr(IDX_INPUT), d, RESP_OKAY);
    chk(d, {24'h00_0000, inS});
    rd(adr(IDX_OUTPUT), d, RESP_OKAY);
    chk(d, {24'h00_0000, outS & 8'hFE});
    chk({25'h000_0000, paths}, 32'h0000_0000);
    $display("test staging done");
    // activate, then commit while the system controller is still busy
    wr(adr(IDX_IRQ_MASK), 8'h03, RESP_OKAY);
    wr(adr(IDX_ACTIVE), 8'h01, RESP_OKAY);
    chk({31'h0000_0000, sysActive}, 32'h0000_0001);
    rd(adr(IDX_STATUS), d, RESP_OKAY);
    chk(d, 32'h0000_0001);
    wr(adr(IDX_INPUT), inS | 8'h01, RESP_OKAY);
    rd(adr(IDX_STATUS), d, RESP_OKAY);
    chk(d, 32'h0000_0003);
    chk({25'h000_0000, paths}, 32'h0000_0000);
    wait_idle();
    chk({25'h000_0000, paths}, exp_paths(inS, outS));
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd(adr(IDX_IRQ_STAT), d, RESP_OKAY);
    chk(d, 32'h0000_0003);
    wr(adr(IDX_IRQ_STAT), 8'h03, RESP_OKAY);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test activate and commit done");
    // masked commit event, then unmask and clear
    wr(adr(IDX_IRQ_MASK), 8'h00, RESP_OKAY);
    inS  = ~inS & 8'hFE;
    outS = ~outS;
    wr(adr(IDX_OUTPUT), outS, RESP_OKAY);
    wr(adr(IDX_INPUT), inS | 8'h01, RESP_OKAY);
    wait_idle();
    chk({25'h000_0000, paths}, exp_paths(inS, outS));
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rd(adr(IDX_IRQ_STAT), d, RESP_OKAY);
    chk(d, 32'h0000_0002);
    wr(adr(IDX_IRQ_MASK), 8'h02, RESP_OKAY);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(adr(IDX_IRQ_STAT), 8'h02, RESP_OKAY);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test masked event done");
    // lane 0 strobe low: answered, but nothing stored
    s_axi_wstrb <= 4'hE;
    wr(adr(IDX_IRQ_MASK), 8'h01, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(adr(IDX_IRQ_MASK), d, RESP_OKAY);
    chk(d, 32'h0000_0002);
    // unmapped and misaligned places, then back to standby
    rd(adr(8'h60), d, RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(adr(8'h60), 8'hFF, RESP_SLVERR);
    rd(12'h141, d, RESP_SLVERR);
    wr(adr(IDX_ACTIVE), 8'h00, RESP_OKAY);
    chk({31'h0000_0000, sysActive}, 32'h0000_0000);
    rd(adr(IDX_STATUS), d, RESP_OKAY);
    chk(d, 32'h0000_0001);
    wait_idle();
    $display("test errors and standby done");
    close_out();
  end
endmodule : testbench

bind smc_mode_ctrl smc_mode_ctrl_asserts u_chk (.clk_sys, .rst_b, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sysActive, .micPathEn, .mixerPathEn,
  .adcPathEn, .hpLeftEn, .hpRightEn, .dacLeftEn, .dacRightEn);

`default_nettype wire
